// ---- core/ltr_defines.svh ----
/*
  Constants for the line thermal replica: widths, fixed-point layout, arithmetic
  scale factors and the reset values of the configuration settings other than the mode.
  Assumes it is included by bare name from every file that needs it.
*/
`ifndef LTR_DEFINES_SVH
`define LTR_DEFINES_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define LTR_SMP_W 16
`define LTR_SQ_W 32
`define LTR_SUM_W 35
`define LTR_PTR_W 5
`define LTR_LVL_W 48
`define LTR_DVD_W 88
`define LTR_DVS_W 56
`define LTR_CNT_W 7
`define LTR_TEMP_W 16

// ****************************************************************
// Arithmetic constants
// ****************************************************************
// Samples in the sliding RMS window, 20 ms at 1 kHz
`define LTR_RMS_WIN 5'h14
// Divider iterations, one per dividend bit
`define LTR_DIV_CYC 7'h58
// Percent squared, 100 * 100
`define LTR_PCT_SCALE 14'h2710
// Time constant unit in 1 ms steps
`define LTR_MS_PER_MIN 16'hea60
// One percent in Q32
`define LTR_PCT_Q32 26'h28f5c29
`define LTR_LVL_MAX 48'hffffffffffff
`define LTR_RISE_MAX 16'h3fff

// ****************************************************************
// Setting reset values
// ****************************************************************
`define LTR_ALARM_DEF 8'h50
`define LTR_TRIP_DEF 8'h64
`define LTR_UNLOCK_DEF 8'h3c
`define LTR_RATED_DEF 8'h64
`define LTR_BASE_DEF 8'h19
`define LTR_AMB_DEF 8'h19
`define LTR_START_DEF 8'h00
`define LTR_INOM_DEF 8'h64
`define LTR_TAU_DEF 10'h00a
`define LTR_SENS_DEF 1'b0

`endif

// ---- core/ltr_pkg.sv ----
/*
  Types for the line thermal replica: operating modes and sequencer states.
  Assumes the defines header is available to the modules that use it.
*/
package ltr_pkg;

  typedef enum logic [1:0] {
    LTR_MODE_OFF,
    LTR_MODE_PULSED,
    LTR_MODE_LATCHED,
    LTR_MODE_RSVD
  } ltr_mode_t;

  typedef enum logic [1:0] {
    LTR_ST_IDLE,
    LTR_ST_RATIO,
    LTR_ST_STEP,
    LTR_ST_TEMP
  } ltr_state_t;

endpackage

// ---- core/ltr_rms_calc.sv ----
/*
  Sliding-window mean-square front end: per phase sum of squared samples over
  the last window of samples, and the largest of the three phases.
  Assumes sample_tick is a one-cycle pulse on clk and samples are stable at it.
*/
`timescale 1ns/100ps
`include "ltr_defines.svh"

module ltr_rms_calc (
  input wire logic clk,
  input wire logic clk_en,
  input wire logic reset_n,
  input wire logic sample_tick,
  input wire logic signed [`LTR_SMP_W-1:0] phase_a_sample,
  input wire logic signed [`LTR_SMP_W-1:0] phase_b_sample,
  input wire logic signed [`LTR_SMP_W-1:0] phase_c_sample,
  output logic [`LTR_SUM_W-1:0] max_sq_sum,
  output logic max_valid
);

  logic signed [`LTR_SMP_W-1:0] smp [3];
  logic [`LTR_SUM_W-1:0] sum [3];
  logic [`LTR_SUM_W-1:0] max01;
  logic [`LTR_PTR_W-1:0] ptr_r;
  logic tick_d_r;

  assign smp[0] = phase_a_sample;
  assign smp[1] = phase_b_sample;
  assign smp[2] = phase_c_sample;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ptr_r <= '0;
      tick_d_r <= 1'b0;
    end else if (clk_en) begin
      tick_d_r <= sample_tick;
      if (sample_tick) begin
        ptr_r <= (ptr_r == `LTR_RMS_WIN - 5'h01) ? '0 : ptr_r + 5'h01;
      end
    end
  end

  // ****************************************************************
  // Per-phase window
  // ****************************************************************
  // Running sum keeps the cost at one add and one subtract per sample
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      logic [`LTR_SQ_W-1:0] hist_r [`LTR_RMS_WIN];
      logic [`LTR_SUM_W-1:0] sum_r;
      logic signed [`LTR_SQ_W-1:0] prod;
      assign prod = smp[g] * smp[g];
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          sum_r <= '0;
          for (int i = 0; i < `LTR_RMS_WIN; i++) begin
            hist_r[i] <= '0;
          end
        end else if (clk_en && sample_tick) begin
          sum_r <= sum_r + {3'b000, prod} - {3'b000, hist_r[ptr_r]};
          hist_r[ptr_r] <= prod;
        end
      end
      assign sum[g] = sum_r;
    end
  endgenerate

  // ****************************************************************
  // Largest phase
  // ****************************************************************
  // Mean square is monotonic in RMS, so the largest sum is the largest RMS
  assign max01 = (sum[0] >= sum[1]) ? sum[0] : sum[1];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      max_sq_sum <= '0;
      max_valid <= 1'b0;
    end else if (clk_en) begin
      max_valid <= tick_d_r;
      if (tick_d_r) begin
        max_sq_sum <= (max01 >= sum[2]) ? max01 : sum[2];
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  max_pick_a: assert property ($past(clk_en) && max_valid |->
    max_sq_sum >= $past(sum[0]) && max_sq_sum >= $past(sum[1]) && max_sq_sum >= $past(sum[2]))
    else $error("max phase sum not the largest");
  ptr_range_a: assert property (ptr_r < `LTR_RMS_WIN)
    else $error("window pointer out of range");

endmodule

// ---- core/ltr_line_thermal_replica.sv ----
/*
  Line thermal replica: from the largest phase mean square it steps a
  first-order thermal level once per sample, adds ambient and drives alarm,
  trip and restart-blocking status.
  Assumes samples, ticks, block and heat-reset inputs come from logic on clk,
  ticks at 1 kHz, and settings are applied by a cfg_load pulse.
*/
`timescale 1ns/100ps
`include "ltr_defines.svh"

module ltr_line_thermal_replica #(
  // Sample code of 100 % device rated current, value arbitrary
  parameter logic [15:0] I_NOM_CODE = 16'h1000
) (
  input wire logic clk,
  input wire logic clk_en,
  input wire logic reset_n,
  input wire logic sample_tick,
  input wire logic signed [`LTR_SMP_W-1:0] phase_a_sample,
  input wire logic signed [`LTR_SMP_W-1:0] phase_b_sample,
  input wire logic signed [`LTR_SMP_W-1:0] phase_c_sample,
  input wire logic signed [7:0] ambient_sensor_temp,
  input wire logic block_in,
  input wire logic heat_reset_in,
  input wire logic cfg_load,
  input wire ltr_pkg::ltr_mode_t operation_mode_select,
  input wire logic [7:0] alarm_temp_threshold,
  input wire logic [7:0] trip_temp_threshold,
  input wire logic [7:0] unlock_temp_threshold,
  input wire logic [7:0] rated_temp_setting,
  input wire logic [7:0] base_temp_setting,
  input wire logic [7:0] ambient_temp_setting,
  input wire logic [7:0] startup_term_pct,
  input wire logic [7:0] rated_load_pct,
  input wire logic [9:0] time_constant_min,
  input wire logic ambient_sensor_select,
  output logic alarm_out,
  output logic trip_out,
  output logic restart_block_out,
  output logic signed [`LTR_TEMP_W-1:0] temperature_out,
  output logic update_done
);

  logic [`LTR_SUM_W-1:0] max_sq_sum;
  logic max_valid;

  ltr_rms_calc u_rms (
    .clk(clk),
    .clk_en(clk_en),
    .reset_n(reset_n),
    .sample_tick(sample_tick),
    .phase_a_sample(phase_a_sample),
    .phase_b_sample(phase_b_sample),
    .phase_c_sample(phase_c_sample),
    .max_sq_sum(max_sq_sum),
    .max_valid(max_valid)
  );

  // ****************************************************************
  // Settings
  // ****************************************************************
  ltr_pkg::ltr_mode_t cfg_mode_r;
  logic [7:0] cfg_alarm_r, cfg_trip_r, cfg_unlock_r, cfg_rated_r;
  logic [7:0] cfg_base_r, cfg_amb_r, cfg_start_r, cfg_inom_r;
  logic [9:0] cfg_tau_r;
  logic cfg_sens_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg_mode_r <= ltr_pkg::LTR_MODE_OFF;
      cfg_alarm_r <= `LTR_ALARM_DEF;
      cfg_trip_r <= `LTR_TRIP_DEF;
      cfg_unlock_r <= `LTR_UNLOCK_DEF;
      cfg_rated_r <= `LTR_RATED_DEF;
      cfg_base_r <= `LTR_BASE_DEF;
      cfg_amb_r <= `LTR_AMB_DEF;
      cfg_start_r <= `LTR_START_DEF;
      cfg_inom_r <= `LTR_INOM_DEF;
      cfg_tau_r <= `LTR_TAU_DEF;
      cfg_sens_r <= `LTR_SENS_DEF;
    end else if (clk_en && cfg_load) begin
      cfg_mode_r <= operation_mode_select;
      cfg_alarm_r <= alarm_temp_threshold;
      cfg_trip_r <= trip_temp_threshold;
      cfg_unlock_r <= unlock_temp_threshold;
      cfg_rated_r <= rated_temp_setting;
      cfg_base_r <= base_temp_setting;
      cfg_amb_r <= ambient_temp_setting;
      cfg_start_r <= startup_term_pct;
      cfg_inom_r <= rated_load_pct;
      cfg_tau_r <= time_constant_min;
      cfg_sens_r <= ambient_sensor_select;
    end
  end

  // ****************************************************************
  // Scaling terms
  // ****************************************************************
  logic [23:0] in_code;
  logic [47:0] in_sq;
  logic [48:0] sum_scaled;
  logic [`LTR_DVS_W-1:0] ratio_dvs, step_dvs;
  logic [`LTR_DVD_W-1:0] ratio_dvd;
  logic [9:0] tau_eff;
  logic [`LTR_LVL_W-1:0] init_level;

  // Level = window sum * 100^2 / (N * (Inom * pct)^2), one at rated load
  assign in_code = {8'h00, I_NOM_CODE} * {16'h0000, cfg_inom_r};
  assign in_sq = {24'h000000, in_code} * {24'h000000, in_code};
  assign ratio_dvs = {8'h00, in_sq} * {51'h0, `LTR_RMS_WIN};
  assign sum_scaled = {14'h0000, max_sq_sum} * {35'h0, `LTR_PCT_SCALE};
  assign ratio_dvd = {7'h00, sum_scaled, 32'h00000000};
  // A zero time constant would divide by zero and give an all-ones quotient
  assign tau_eff = (cfg_tau_r == 10'h000) ? 10'h001 : cfg_tau_r;
  assign step_dvs = {30'h0, {16'h0000, tau_eff} * {10'h000, `LTR_MS_PER_MIN}};
  assign init_level = {40'h0, cfg_start_r} * {22'h0, `LTR_PCT_Q32};

  // ****************************************************************
  // Sequencer and divider
  // ****************************************************************
  ltr_pkg::ltr_state_t st_r;
  logic [`LTR_DVS_W:0] rem_r, rem_sh;
  logic [`LTR_DVD_W-1:0] quo_r, div_dvd;
  logic [`LTR_DVS_W-1:0] dvs_r, div_dvs;
  logic [`LTR_CNT_W-1:0] div_cnt_r;
  logic rem_ge, div_done, div_load, start_ratio, start_step, reinit, init_pending_r;
  logic [`LTR_LVL_W-1:0] level_r, ratio_r, ratio_sat;
  logic [`LTR_LVL_W:0] diff, diff_mag;
  logic step_neg_r;

  assign reinit = heat_reset_in || init_pending_r;
  assign div_done = (div_cnt_r == '0);
  assign start_ratio = (st_r == ltr_pkg::LTR_ST_IDLE) && max_valid && !reinit;
  assign start_step = (st_r == ltr_pkg::LTR_ST_RATIO) && div_done && !reinit;
  assign div_load = start_ratio || start_step;
  assign ratio_sat = (|quo_r[`LTR_DVD_W-1:`LTR_LVL_W]) ? `LTR_LVL_MAX : quo_r[`LTR_LVL_W-1:0];
  assign diff = {1'b0, ratio_sat} - {1'b0, level_r};
  assign diff_mag = diff[`LTR_LVL_W] ? ('0 - diff) : diff;
  assign div_dvd = start_ratio ? ratio_dvd : {40'h0, diff_mag[`LTR_LVL_W-1:0]};
  assign div_dvs = start_ratio ? ratio_dvs : step_dvs;
  assign rem_sh = {rem_r[`LTR_DVS_W-1:0], quo_r[`LTR_DVD_W-1]};
  assign rem_ge = rem_sh >= {1'b0, dvs_r};

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= ltr_pkg::LTR_ST_IDLE;
    end else if (clk_en) begin
      if (reinit) begin
        st_r <= ltr_pkg::LTR_ST_TEMP;
      end else begin
        case (st_r)
          ltr_pkg::LTR_ST_IDLE: if (max_valid) st_r <= ltr_pkg::LTR_ST_RATIO;
          ltr_pkg::LTR_ST_RATIO: if (div_done) st_r <= ltr_pkg::LTR_ST_STEP;
          ltr_pkg::LTR_ST_STEP: if (div_done) st_r <= ltr_pkg::LTR_ST_TEMP;
          default: st_r <= ltr_pkg::LTR_ST_IDLE;
        endcase
      end
    end
  end

  // Restoring divider shared by the ratio and the step; about 180 cycles per
  // sample, far inside the 1 ms sample period
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rem_r <= '0;
      quo_r <= '0;
      dvs_r <= '0;
      div_cnt_r <= '0;
    end else if (clk_en) begin
      if (div_load) begin
        rem_r <= '0;
        quo_r <= div_dvd;
        dvs_r <= div_dvs;
        div_cnt_r <= `LTR_DIV_CYC;
      end else if (!div_done) begin
        rem_r <= rem_ge ? rem_sh - {1'b0, dvs_r} : rem_sh;
        quo_r <= {quo_r[`LTR_DVD_W-2:0], rem_ge};
        div_cnt_r <= div_cnt_r - 7'h01;
      end
    end
  end

  // ****************************************************************
  // Thermal level
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      level_r <= '0;
      ratio_r <= '0;
      step_neg_r <= 1'b0;
      init_pending_r <= 1'b1;
    end else if (clk_en) begin
      if (reinit) begin
        level_r <= init_level;
        init_pending_r <= 1'b0;
      end else begin
        if (start_step) begin
          ratio_r <= ratio_sat;
          step_neg_r <= diff[`LTR_LVL_W];
        end
        // Quotient never exceeds the gap, so the level cannot overshoot
        if (st_r == ltr_pkg::LTR_ST_STEP && div_done) begin
          level_r <= step_neg_r ? level_r - quo_r[`LTR_LVL_W-1:0]
                                : level_r + quo_r[`LTR_LVL_W-1:0];
        end
      end
    end
  end

  // ****************************************************************
  // Temperature and status
  // ****************************************************************
  logic [8:0] rated_rise;
  logic [7:0] rise_k;
  logic [55:0] rise_full;
  logic [15:0] rise_sat, amb_now;
  logic signed [`LTR_TEMP_W-1:0] temp_nxt;
  logic gt_alarm, gt_trip, gt_unlock, lt_unlock, active, above_trip_r;

  assign rated_rise = {1'b0, cfg_rated_r} - {1'b0, cfg_base_r};
  assign rise_k = rated_rise[8] ? 8'h00 : rated_rise[7:0];
  assign rise_full = {8'h00, level_r} * {48'h0, rise_k};
  assign rise_sat = (|rise_full[55:46]) ? `LTR_RISE_MAX : {2'b00, rise_full[45:32]};
  assign amb_now = cfg_sens_r ? {{8{ambient_sensor_temp[7]}}, ambient_sensor_temp}
                              : {8'h00, cfg_amb_r};
  assign temp_nxt = $signed(amb_now + rise_sat);
  assign gt_alarm = temp_nxt > $signed({8'h00, cfg_alarm_r});
  assign gt_trip = temp_nxt > $signed({8'h00, cfg_trip_r});
  assign gt_unlock = temp_nxt > $signed({8'h00, cfg_unlock_r});
  assign lt_unlock = temp_nxt < $signed({8'h00, cfg_unlock_r});
  assign active = (cfg_mode_r == ltr_pkg::LTR_MODE_PULSED ||
                   cfg_mode_r == ltr_pkg::LTR_MODE_LATCHED) && !block_in;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      temperature_out <= '0;
      update_done <= 1'b0;
    end else if (clk_en) begin
      update_done <= (st_r == ltr_pkg::LTR_ST_TEMP);
      if (st_r == ltr_pkg::LTR_ST_TEMP) begin
        temperature_out <= temp_nxt;
      end
    end
  end

  // Status is compared against the thresholds only in the temperature state, after a step or a heat reset; the replica keeps running while
  // suppressed so its heat memory survives a block
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      alarm_out <= 1'b0;
      trip_out <= 1'b0;
      restart_block_out <= 1'b0;
      above_trip_r <= 1'b0;
    end else if (clk_en) begin
      if (!active) begin
        alarm_out <= 1'b0;
        trip_out <= 1'b0;
        restart_block_out <= 1'b0;
        above_trip_r <= 1'b0;
      end else if (st_r == ltr_pkg::LTR_ST_TEMP) begin
        alarm_out <= gt_alarm;
        restart_block_out <= gt_unlock;
        above_trip_r <= gt_trip;
        if (cfg_mode_r == ltr_pkg::LTR_MODE_PULSED) begin
          trip_out <= gt_trip && !above_trip_r;
        end else if (gt_trip) begin
          trip_out <= 1'b1;
        end else if (lt_unlock) begin
          trip_out <= 1'b0;
        end
      end else if (cfg_mode_r == ltr_pkg::LTR_MODE_PULSED) begin
        trip_out <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  off_quiet_a: assert property ($past(reset_n && clk_en) &&
    $past(cfg_mode_r) == ltr_pkg::LTR_MODE_OFF |-> !alarm_out && !trip_out && !restart_block_out)
    else $error("status active in off mode");
  block_quiet_a: assert property ($past(reset_n && clk_en && block_in) |->
    !alarm_out && !trip_out && !restart_block_out)
    else $error("status active while blocked");
  init_load_a: assert property ($past(reset_n && clk_en && init_pending_r) |->
    level_r == $past(init_level) && !init_pending_r)
    else $error("startup level not loaded");
  heat_reset_a: assert property ($past(reset_n && clk_en && heat_reset_in) |->
    level_r == $past(init_level) ##1 update_done || !clk_en)
    else $error("heat reset not applied");
  alarm_set_a: assert property (clk_en && st_r == ltr_pkg::LTR_ST_TEMP && active &&
    gt_alarm |=> alarm_out && temperature_out > $signed({8'h00, cfg_alarm_r}))
    else $error("alarm missing above threshold");
  pulse_short_a: assert property (clk_en && trip_out &&
    cfg_mode_r == ltr_pkg::LTR_MODE_PULSED |=> !trip_out)
    else $error("pulsed trip longer than one cycle");
  latch_hold_a: assert property (clk_en && cfg_mode_r == ltr_pkg::LTR_MODE_LATCHED &&
    active && trip_out && !(st_r == ltr_pkg::LTR_ST_TEMP && lt_unlock) |=> trip_out)
    else $error("latched trip released early");
  step_dir_a: assert property (clk_en && !reinit && st_r == ltr_pkg::LTR_ST_STEP &&
    div_done |=> $past(ratio_r >= level_r) ? level_r >= $past(level_r) : level_r <= $past(level_r))
    else $error("level moved away from steady value");
  no_overshoot_a: assert property (clk_en && !reinit && st_r == ltr_pkg::LTR_ST_STEP &&
    div_done && ratio_r >= level_r |=> level_r <= $past(ratio_r))
    else $error("level stepped past steady value");
  amb_fixed_a: assert property (clk_en && st_r == ltr_pkg::LTR_ST_TEMP && !cfg_sens_r |=>
    temperature_out == $signed({8'h00, $past(cfg_amb_r)} + $past(rise_sat)))
    else $error("fixed ambient not used");
  cfg_default_a: assert property ($past(!reset_n) |-> cfg_alarm_r == `LTR_ALARM_DEF &&
    cfg_trip_r == `LTR_TRIP_DEF && cfg_unlock_r == `LTR_UNLOCK_DEF)
    else $error("threshold defaults wrong");
  sens_default_a: assert property ($past(!reset_n) |-> cfg_sens_r == `LTR_SENS_DEF)
    else $error("ambient source default wrong");

  pulse_c: cover property (trip_out && cfg_mode_r == ltr_pkg::LTR_MODE_PULSED);
  latch_c: cover property (trip_out && cfg_mode_r == ltr_pkg::LTR_MODE_LATCHED ##1 !trip_out);
  alarm_c: cover property (alarm_out && !trip_out);
  heat_c: cover property (restart_block_out ##1 heat_reset_in);

endmodule

// ---- verification/ltr_front_end_model.sv ----
/*
  Sampling front end model: a periodic sample tick and three phase samples.
  Assumes the replica clock; the tick period is scaled down from 1 ms to keep runs short.
*/
`timescale 1ns/100ps

module ltr_front_end_model #(
  parameter int TICK_CYC = 250
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tick_en,
  input wire logic signed [15:0] amp_a,
  input wire logic signed [15:0] amp_b,
  input wire logic signed [15:0] amp_c,
  output logic sample_tick,
  output logic signed [15:0] phase_a_sample,
  output logic signed [15:0] phase_b_sample,
  output logic signed [15:0] phase_c_sample
);
  int cnt;
  logic last;

  assign last = tick_en && cnt == TICK_CYC - 1;

  always_ff @(posedge clk) begin
    if (!reset_n || !tick_en) begin
      cnt <= 0;
    end else begin
      cnt <= last ? 0 : cnt + 1;
    end
  end

  always_ff @(posedge clk) begin
    sample_tick <= reset_n && last;
  end

  // Outside the tick the samples mean nothing, so they toggle instead of holding
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase_a_sample <= 16'h0000;
      phase_b_sample <= 16'h0000;
      phase_c_sample <= 16'h0000;
    end else if (last) begin
      phase_a_sample <= amp_a;
      phase_b_sample <= amp_b;
      phase_c_sample <= amp_c;
    end else begin
      phase_a_sample <= ~phase_a_sample;
      phase_b_sample <= ~phase_b_sample;
      phase_c_sample <= ~phase_c_sample;
    end
  end
endmodule

// ---- verification/tb_top.sv ----
/*
  Self-checking bench for the line thermal replica: settings, heat reset, block
  and sampled currents, each refresh checked against a reference model.
  Assumes the design sources and package are compiled first.
*/
`timescale 1ns/100ps

module tb_top;
  typedef struct packed {
    logic signed [15:0] t;
    logic [3:0] st;
    logic chk;
  } ltr_exp_t;

  logic clk, reset_n, tick_en, block_in, heat_reset_in, cfg_load, ambient_sensor_select;
  ltr_pkg::ltr_mode_t operation_mode_select;
  logic [7:0] alarm_temp_threshold, trip_temp_threshold, unlock_temp_threshold;
  logic [7:0] rated_temp_setting, base_temp_setting, ambient_temp_setting;
  logic [7:0] startup_term_pct, rated_load_pct;
  logic [9:0] time_constant_min;
  logic signed [7:0] ambient_sensor_temp;
  logic signed [15:0] amp_a, amp_b, amp_c, phase_a_sample, phase_b_sample, phase_c_sample;
  logic sample_tick, alarm_out, trip_out, restart_block_out, update_done, trip_prev_r, upd_d_r;
  logic signed [15:0] temperature_out;
  ltr_exp_t exp_q[$];
  ltr_exp_t e_m;
  int err_count, n_compared, seed, k;
  bit trip_st, over_prev;
  real lvl, ratio;

  ltr_front_end_model fe (.clk, .reset_n, .tick_en, .amp_a, .amp_b, .amp_c, .sample_tick,
    .phase_a_sample, .phase_b_sample, .phase_c_sample);

  ltr_line_thermal_replica #(.I_NOM_CODE(16'h0100)) uut (.clk, .clk_en(1'b1), .reset_n,
    .sample_tick, .phase_a_sample, .phase_b_sample, .phase_c_sample, .ambient_sensor_temp,
    .block_in, .heat_reset_in, .cfg_load, .operation_mode_select, .alarm_temp_threshold,
    .trip_temp_threshold, .unlock_temp_threshold, .rated_temp_setting, .base_temp_setting,
    .ambient_temp_setting, .startup_term_pct, .rated_load_pct, .time_constant_min,
    .ambient_sensor_select, .alarm_out, .trip_out, .restart_block_out, .temperature_out,
    .update_done);

  // ****************************************************************
  // Reporting
  // ****************************************************************
  task automatic summarize;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp_temp(input logic signed [15:0] exp, input logic signed [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic cmp_stat(input logic [3:0] exp, input logic [3:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic give_up(input int left);
    err_count++;
    $display("[FAIL] t=%0t exp=%h got=%h", $time, 0, left);
    summarize();
  endtask

  // ****************************************************************
  // Reference model and drivers
  // ****************************************************************
  // Status bits: alarm, trip during the refresh pulse, trip one cycle later, restart block
  task automatic expect_upd(input logic signed [15:0] t, input bit blk);
    ltr_exp_t e;
    bit over;
    bit pulse;
    over = int'(t) > int'(trip_temp_threshold);
    pulse = operation_mode_select == ltr_pkg::LTR_MODE_PULSED && over && !over_prev;
    if (operation_mode_select != ltr_pkg::LTR_MODE_LATCHED)
      trip_st = 1'b0;
    else if (over)
      trip_st = 1'b1;
    else if (int'(t) < int'(unlock_temp_threshold))
      trip_st = 1'b0;
    over_prev = over;
    e.t = t;
    e.chk = !blk;
    e.st = 4'h0;
    if (!blk && operation_mode_select inside {ltr_pkg::LTR_MODE_PULSED, ltr_pkg::LTR_MODE_LATCHED})
      e.st = {int'(t) > int'(alarm_temp_threshold), trip_st | pulse, trip_st,
        int'(t) > int'(unlock_temp_threshold)};
    exp_q.push_back(e);
  endtask

  task automatic drain;
    for (int i = 0; i < 400 && exp_q.size() > 0; i++)
      @(posedge clk);
    if (exp_q.size() > 0)
      give_up(exp_q.size());
  endtask

  task automatic cfg(input ltr_pkg::ltr_mode_t m, input logic [7:0] st, input logic sens);
    @(posedge clk);
    operation_mode_select <= m;
    startup_term_pct <= st;
    ambient_sensor_select <= sens;
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
  endtask

  task automatic heat(input logic signed [15:0] t, input bit blk);
    expect_upd(t, blk);
    @(posedge clk);
    heat_reset_in <= 1'b1;
    @(posedge clk);
    heat_reset_in <= 1'b0;
    drain();
  endtask

  task automatic wait_tick;
    for (int i = 0; i < 300 && sample_tick !== 1'b1; i++)
      @(posedge clk);
    if (sample_tick !== 1'b1)
      give_up(0);
  endtask

  // ****************************************************************
  // Clock, monitor and main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    trip_prev_r <= trip_out;
    upd_d_r <= update_done;
    // Looked at one cycle after the refresh, so a pulsed trip must already be gone
    if (upd_d_r === 1'b1) begin
      if (exp_q.size() == 0) begin
        cmp_stat(4'h0, 4'hf);
      end else begin
        e_m = exp_q.pop_front();
        cmp_stat(e_m.st, {alarm_out, trip_prev_r, trip_out, restart_block_out});
        if (e_m.chk)
          cmp_temp(e_m.t, temperature_out);
      end
    end
  end

  initial begin
    seed = 32'h0291;
    reset_n = 1'b0;
    tick_en = 1'b0;
    block_in = 1'b0;
    heat_reset_in = 1'b0;
    cfg_load = 1'b0;
    ambient_sensor_select = 1'b0;
    operation_mode_select = ltr_pkg::LTR_MODE_OFF;
    alarm_temp_threshold = 8'h50;
    trip_temp_threshold = 8'h64;
    unlock_temp_threshold = 8'h3c;
    rated_temp_setting = 8'hc8;
    base_temp_setting = 8'h00;
    ambient_temp_setting = 8'h19;
    startup_term_pct = 8'h00;
    rated_load_pct = 8'h64;
    time_constant_min = 10'h001;
    ambient_sensor_temp = -8'sd10;
    amp_a = 16'h0000;
    amp_b = 16'h0000;
    amp_c = 16'h0000;
    lvl = 0.0;
    // Sensor reads -10 here, so a 25 degree result shows the fixed setting is in use
    expect_upd(16'sd25, 1'b0);
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    drain();
    cfg(ltr_pkg::LTR_MODE_LATCHED, 8'h32, 1'b0);
    heat(16'sd125, 1'b0);
    cfg(ltr_pkg::LTR_MODE_LATCHED, 8'h00, 1'b1);
    heat(-16'sd10, 1'b0);
    cfg(ltr_pkg::LTR_MODE_PULSED, 8'h32, 1'b0);
    heat(16'sd125, 1'b0);
    heat(16'sd125, 1'b0);
    block_in <= 1'b1;
    heat(16'sd125, 1'b1);
    block_in <= 1'b0;
    cfg(ltr_pkg::LTR_MODE_OFF, 8'h32, 1'b0);
    heat(16'sd125, 1'b0);
    cfg(ltr_pkg::LTR_MODE_LATCHED, 8'h00, 1'b0);
    heat(16'sd25, 1'b0);
    // Phase b dominates; a negative code also proves the squaring
    amp_b <= -16'sd32767;
    tick_en <= 1'b1;
    for (k = 1; k <= 25; k++) begin
      amp_a <= 16'($random(seed) % 2000);
      amp_c <= 16'($random(seed) % 2000);
      wait_tick();
      ratio = (k < 20 ? k : 20) * 32767.0 * 32767.0 * 500.0 / (256.0 * rated_load_pct) ** 2;
      lvl = lvl + (ratio - lvl) / (60000.0 * time_constant_min);
      expect_upd(16'(25 + $rtoi(lvl * 200.0)), 1'b0);
      drain();
    end
    summarize();
  end
endmodule
